// file: src/dac_power_format_regs.sv
// channel power-down, temperature readout and serial format registers
// assumes an APB4 master on sys_clk_i and a temperature sensor that presents
// a code and toggles temp_toggle_i once the code is stable
//
// Decided for this implementation: the APB register port.
`include "dac_cfg_regs.svh"

// How it works
// RULE1: low register bits power down channels 1-8
// RULE2: high register bits 0-3 power channels 9-12
// RULE3: both power-down registers reset to zero
// RULE4: read-only temperature code, code minus 60
// RULE5: code spans -60 to +140, one degree
// RULE6: temperature reads zero until first conversion
// RULE7: stereo format selects data delay
// RULE8: stereo format only used in stereo layout
// RULE9: layout field selects stereo or TDM lanes
// RULE10: rate field selects rate family
// RULE11: format register resets 0x01, global mute set
// RULE12: software avoids reserved layouts; treated stereo
// RULE13: high register bits 7-4 read zero
module dac_power_format_regs (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire dac_cfg_pkg::apb_req_t apb_req_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o,
    input wire logic [7:0] temp_code_i,
    input wire logic temp_toggle_i,
    output logic [11:0] channel_off_o,
    output dac_cfg_pkg::audio_cfg_t audio_cfg_o,
    output logic signed [8:0] temp_celsius_o
);
    import dac_cfg_pkg::*;

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    logic setup_phase;
    logic access_phase;
    logic write_taken;
    logic hit_low;
    logic hit_high;
    logic hit_temp;
    logic hit_format;
    logic mapped;
    logic [7:0] pdn_low;
    logic [7:0] pdn_high;
    logic [7:0] format_q;
    logic [7:0] temp_q;
    logic temp_seen;
    logic [31:0] next_prdata;

    assign setup_phase = apb_req_i.psel && !apb_req_i.penable;
    assign access_phase = apb_req_i.psel && apb_req_i.penable;
    assign hit_low = apb_req_i.paddr == `BYTE_ADDR(`IDX_PDN_LOW);
    assign hit_high = apb_req_i.paddr == `BYTE_ADDR(`IDX_PDN_HIGH);
    assign hit_temp = apb_req_i.paddr == `BYTE_ADDR(`IDX_TEMP);
    assign hit_format = apb_req_i.paddr == `BYTE_ADDR(`IDX_FORMAT);
    assign mapped = hit_low || hit_high || hit_temp || hit_format;
    // only byte lane 0 carries register data, so only its strobe counts
    assign write_taken = access_phase && pready_o && apb_req_i.pwrite && !pslverr_o
        && apb_req_i.pstrb[0];

    // ------------------------------------------------------------------------
    // bus answer: always one wait-free access phase after setup
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= setup_phase;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= setup_phase && !mapped;
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_low) begin
            next_prdata[7:0] = pdn_low;
        end else if (hit_high) begin
            next_prdata[7:0] = pdn_high; // see RULE13
        end else if (hit_temp) begin
            next_prdata[7:0] = temp_q; // see RULE4
        end else if (hit_format) begin
            next_prdata[7:0] = format_q;
        end
    end

    // read data is latched in the setup cycle so it leaves a flop
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup_phase && !apb_req_i.pwrite) begin
            prdata_o <= next_prdata;
        end else if (!apb_req_i.psel) begin
            prdata_o <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------------
    ctrl_reg8 #(
        .RESET_VALUE(`RST_PDN_LOW),
        .WRITE_MASK(`WMASK_PDN_LOW)
    ) u_pdn_low (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .write_i(write_taken && hit_low), // see RULE1 see RULE3
        .wdata_i(apb_req_i.pwdata[7:0]),
        .value_o(pdn_low)
    );

    ctrl_reg8 #(
        .RESET_VALUE(`RST_PDN_HIGH),
        .WRITE_MASK(`WMASK_PDN_HIGH) // see RULE13
    ) u_pdn_high (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .write_i(write_taken && hit_high), // see RULE2 see RULE3
        .wdata_i(apb_req_i.pwdata[7:0]),
        .value_o(pdn_high)
    );

    ctrl_reg8 #(
        .RESET_VALUE(`RST_FORMAT), // see RULE11
        .WRITE_MASK(`WMASK_FORMAT)
    ) u_format (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .write_i(write_taken && hit_format),
        .wdata_i(apb_req_i.pwdata[7:0]),
        .value_o(format_q)
    );

    // ------------------------------------------------------------------------
    // temperature capture from the sensor
    // ------------------------------------------------------------------------
    logic toggle_sync;
    logic toggle_seen;
    logic new_code;

    sync2 u_toggle_sync (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .async_i(temp_toggle_i),
        .sync_o(toggle_sync)
    );

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            toggle_seen <= 1'b0;
        end else begin
            toggle_seen <= toggle_sync;
        end
    end

    // the sync flops reset low, so a toggle pin left high across reset
    // release is taken as one new code: the sensor must idle it low
    assign new_code = toggle_sync != toggle_seen;

    logic [7:0] code_meta;
    logic [7:0] code_sync;

    // the code bus passes two flops as well; the sensor holds it stable from
    // before the toggle, so every bit has settled when the toggle is seen
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            code_meta <= `RST_TEMP;
            code_sync <= `RST_TEMP;
        end else begin
            code_meta <= temp_code_i;
            code_sync <= code_meta;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            temp_q <= `RST_TEMP; // see RULE6
        end else if (new_code) begin
            if (code_sync > `TEMP_CODE_MAX) begin
                temp_q <= `TEMP_CODE_MAX; // see RULE5
            end else begin
                temp_q <= code_sync;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            temp_seen <= 1'b0;
        end else if (new_code) begin
            temp_seen <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            temp_celsius_o <= 9'sh000;
        end else begin
            temp_celsius_o <= $signed({1'b0, temp_q}) - $signed(`TEMP_OFFSET); // see RULE4
        end
    end

    // ------------------------------------------------------------------------
    // decode of the audio setup
    // ------------------------------------------------------------------------
    layout_t next_layout;
    logic [4:0] next_delay;

    always_comb begin
        unique case (format_q[`FLD_LAYOUT]) // see RULE9
            3'h1: next_layout = LAYOUT_TDM2;
            3'h2: next_layout = LAYOUT_TDM4;
            3'h3: next_layout = LAYOUT_TDM8;
            3'h4: next_layout = LAYOUT_SIXTEEN_SLOT;
            default: next_layout = LAYOUT_STEREO; // see RULE12
        endcase
    end

    always_comb begin
        next_delay = `DELAY_TDM; // see RULE8
        if (next_layout == LAYOUT_STEREO) begin
            unique case (stereo_fmt_t'(format_q[`FLD_STEREO])) // see RULE7
                STEREO_I2S: next_delay = `DELAY_I2S;
                STEREO_LEFT: next_delay = `DELAY_LEFT;
                STEREO_RIGHT24: next_delay = `DELAY_RIGHT24;
                STEREO_RIGHT16: next_delay = `DELAY_RIGHT16;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            audio_cfg_o.layout <= LAYOUT_STEREO;
            audio_cfg_o.data_delay <= `DELAY_I2S;
            audio_cfg_o.rate_family <= 2'h0;
            audio_cfg_o.low_latency <= 1'b0;
            audio_cfg_o.global_mute <= 1'b1;
        end else begin
            audio_cfg_o.layout <= next_layout;
            audio_cfg_o.data_delay <= next_delay;
            // the low-delay code shares the highest rate family
            audio_cfg_o.rate_family <= format_q[`FLD_RATE] == 2'h3 ? 2'h2
                : format_q[`FLD_RATE]; // see RULE10
            audio_cfg_o.low_latency <= format_q[`FLD_RATE] == 2'h3; // see RULE10
            audio_cfg_o.global_mute <= format_q[`FLD_MUTE]; // see RULE11
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            channel_off_o <= 12'h000;
        end else begin
            channel_off_o <= {pdn_high[3:0], pdn_low}; // see RULE1 see RULE2
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_LOW_CHANNELS: assert property ( // see RULE1
        write_taken && hit_low |=> ##1 channel_off_o[7:0] == $past(apb_req_i.pwdata[7:0], 2))
        else $error("low channel power-down did not follow the write");

    AST_HIGH_CHANNELS: assert property ( // see RULE2
        write_taken && hit_high |=> ##1 channel_off_o[11:8] == $past(apb_req_i.pwdata[3:0], 2))
        else $error("high channel power-down did not follow the write");

    AST_PDN_RESET: assert property ( // see RULE3
        $rose(resetn_i) |-> channel_off_o == 12'h000 && pdn_low == 8'h00 && pdn_high == 8'h00)
        else $error("power-down registers not clear after reset");

    AST_TEMP_READ: assert property ( // see RULE4
        access_phase && !apb_req_i.pwrite && hit_temp && $stable(temp_q)
        |-> prdata_o == {24'h000000, temp_q})
        else $error("temperature read returned a wrong code");

    AST_TEMP_RANGE: assert property ( // see RULE5
        temp_q <= `TEMP_CODE_MAX && temp_celsius_o <= 9'sd140 && temp_celsius_o >= -9'sd60)
        else $error("temperature outside the reported range");

    AST_TEMP_ZERO: assert property ( // see RULE6
        !temp_seen |-> temp_q == 8'h00)
        else $error("temperature nonzero before any conversion");

    AST_RIGHT24_DELAY: assert property ( // see RULE7
        format_q[`FLD_LAYOUT] == 3'h0 && format_q[`FLD_STEREO] == 2'h2
        |=> audio_cfg_o.data_delay == 5'h08)
        else $error("right justified 24-bit delay is not eight");

    AST_TDM_IGNORES_FMT: assert property ( // see RULE8
        format_q[`FLD_LAYOUT] inside {3'h1, 3'h2, 3'h3, 3'h4}
        |=> audio_cfg_o.data_delay == `DELAY_TDM)
        else $error("stereo format leaked into a TDM layout");

    AST_SIXTEEN_SLOT_LAYOUT: assert property ( // see RULE9
        format_q[`FLD_LAYOUT] == 3'h4 |=> audio_cfg_o.layout == LAYOUT_SIXTEEN_SLOT)
        else $error("single-line sixteen-slot layout not selected");

    AST_LOW_DELAY_RATE: assert property ( // see RULE10
        format_q[`FLD_RATE] == 2'h3
        |=> audio_cfg_o.low_latency && audio_cfg_o.rate_family == 2'h2)
        else $error("low delay rate code decoded wrongly");

    AST_UNMUTE: assert property ( // see RULE11
        write_taken && hit_format && !apb_req_i.pwdata[0] |=> ##1 !audio_cfg_o.global_mute)
        else $error("clearing global mute had no effect");

    AST_HIGH_UPPER_ZERO: assert property ( // see RULE13
        access_phase && !apb_req_i.pwrite && hit_high |-> prdata_o[7:4] == 4'h0)
        else $error("unused power-down bits read nonzero");

endmodule

// file: src/dac_cfg_regs.svh
// register map constants for the channel power-down, temperature readout and
// serial format block; assumes an 8-bit APB byte address and 8-bit registers
`ifndef DAC_CFG_REGS_SVH
`define DAC_CFG_REGS_SVH

// ----------------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------------
`define IDX_PDN_LOW 8'h03
`define IDX_PDN_HIGH 8'h04
`define IDX_TEMP 8'h05
`define IDX_FORMAT 8'h06
`define BYTE_ADDR(idx) ((idx) << 2)

// ----------------------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------------------
`define RST_PDN_LOW 8'h00
`define RST_PDN_HIGH 8'h00
`define RST_TEMP 8'h00
`define RST_FORMAT 8'h01
`define WMASK_PDN_LOW 8'hff
`define WMASK_PDN_HIGH 8'h0f
`define WMASK_FORMAT 8'hff

// ----------------------------------------------------------------------------
// fields of the serial format control register
// ----------------------------------------------------------------------------
`define FLD_STEREO 7:6
`define FLD_LAYOUT 5:3
`define FLD_RATE 2:1
`define FLD_MUTE 0

// ----------------------------------------------------------------------------
// temperature code and data delays in bit clocks
// ----------------------------------------------------------------------------
`define TEMP_OFFSET 9'h03c
`define TEMP_CODE_MAX 8'hc8
`define DELAY_I2S 5'h01
`define DELAY_LEFT 5'h00
`define DELAY_RIGHT24 5'h08
`define DELAY_RIGHT16 5'h10
`define DELAY_TDM 5'h01

`endif

// file: src/dac_cfg_pkg.sv
// types shared by the register block and its bench
// assumes dac_cfg_regs.svh supplies all numeric constants
package dac_cfg_pkg;

    // ------------------------------------------------------------------------
    // serial data lane layout, coded as stored in the register
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        LAYOUT_STEREO = 3'h0,
        LAYOUT_TDM2 = 3'h1,
        LAYOUT_TDM4 = 3'h2,
        LAYOUT_TDM8 = 3'h3,
        LAYOUT_SIXTEEN_SLOT = 3'h4
    } layout_t;

    typedef enum logic [1:0] {
        STEREO_I2S = 2'h0,
        STEREO_LEFT = 2'h1,
        STEREO_RIGHT24 = 2'h2,
        STEREO_RIGHT16 = 2'h3
    } stereo_fmt_t;

    // ------------------------------------------------------------------------
    // bus request and decoded audio setup
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

    typedef struct packed {
        layout_t layout;
        logic [4:0] data_delay;
        logic [1:0] rate_family;
        logic low_latency;
        logic global_mute;
    } audio_cfg_t;

endpackage

// file: src/sync2.sv
// two flip-flop synchroniser for a single level
// assumes the input may change at any time relative to sys_clk_i
module sync2 (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic async_i,
    output logic sync_o
);
    logic stage1;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage1 <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule

// file: src/ctrl_reg8.sv
// one 8-bit software register with a write mask; masked bits hold their
// reset value forever and read back as that value
module ctrl_reg8 #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hff
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic write_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] value_o
);
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            value_o <= RESET_VALUE;
        end else if (write_i) begin
            value_o <= (wdata_i & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
        end
    end
endmodule

// file: bench/test_dac_power_format_regs.sv
// self-checking bench for the power-down, temperature and format registers
// assumes the design answers apb with its own pready_o and a sensor driven here
`include "dac_cfg_regs.svh"

module test_dac_power_format_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import dac_cfg_pkg::*;

    logic sys_clk_i;
    logic resetn_i;
    apb_req_t req;
    logic pready_o;
    logic pslverr_o;
    logic [31:0] prdata_o;
    logic [7:0] temp_code_i;
    logic temp_toggle_i;
    logic [11:0] channel_off_o;
    audio_cfg_t audio_cfg_o;
    logic signed [8:0] temp_celsius_o;
    int mismatches;
    int samples_checked;
    int cycles;
    logic [31:0] rd;
    logic err;
    logic [7:0] fmt;
    logic [2:0] exp_layout;
    logic [4:0] exp_delay;

    dac_power_format_regs dut_u (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .apb_req_i(req),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .prdata_o(prdata_o),
        .temp_code_i(temp_code_i),
        .temp_toggle_i(temp_toggle_i),
        .channel_off_o(channel_off_o),
        .audio_cfg_o(audio_cfg_o),
        .temp_celsius_o(temp_celsius_o)
    );

    // ------------------------------------------------------------------------
    // clock, timeout and report
    // ------------------------------------------------------------------------
    always #50 sys_clk_i = ~sys_clk_i;

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // the whole sequence needs well under 3000 cycles
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
        samples_checked++;
        if (seen !== expd) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, expd, seen);
        end
    endtask

    // ------------------------------------------------------------------------
    // apb master: signals change right after a rising edge and hold until pready
    // ------------------------------------------------------------------------
    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata, output logic perr);
        @(posedge sys_clk_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata,
                 pstrb: 4'hf};
        @(posedge sys_clk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk_i);
        end while (pready_o !== 1'b1);
        rdata = prdata_o;
        perr = pslverr_o;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
        apb_xfer(1'b1, addr, wdata, rd, err);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] expd);
        apb_xfer(1'b0, addr, 32'h0, rd, err);
        check({what, " err"}, {31'h0, err}, 32'h0);
        check(what, rd, {24'h0, expd});
    endtask

    // register-derived outputs follow the register one edge later
    task automatic settle();
        repeat (3) @(posedge sys_clk_i);
    endtask

    task automatic sense(input logic [7:0] code);
        @(posedge sys_clk_i);
        temp_code_i <= code;
        @(posedge sys_clk_i);
        temp_toggle_i <= ~temp_toggle_i;
        repeat (8) @(posedge sys_clk_i);
    endtask

    // ------------------------------------------------------------------------
    // reset and the values that must follow it
    // ------------------------------------------------------------------------
    task automatic reset_and_check();
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        settle();
        check("channel_off_o", {20'h0, channel_off_o}, 32'h0);
        check("global_mute", {31'h0, audio_cfg_o.global_mute}, 32'h1);
        check("temp_celsius_o", {23'h0, temp_celsius_o}, {23'h0, 9'h1c4});
        rd_chk("pdn_low reset", `BYTE_ADDR(`IDX_PDN_LOW), 8'h00);
        rd_chk("pdn_high reset", `BYTE_ADDR(`IDX_PDN_HIGH), 8'h00);
        rd_chk("temp reset", `BYTE_ADDR(`IDX_TEMP), 8'h00);
        rd_chk("format reset", `BYTE_ADDR(`IDX_FORMAT), 8'h01);
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        resetn_i = 1'b0;
        req = '0;
        temp_code_i = 8'h00;
        temp_toggle_i = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        reset_and_check();

        // power-down bits, upper bus bytes must not leak into the registers
        wr(`BYTE_ADDR(`IDX_PDN_LOW), 32'hffffffa5);
        wr(`BYTE_ADDR(`IDX_PDN_HIGH), 32'hffffffff);
        settle();
        check("channel_off_o", {20'h0, channel_off_o}, 32'h00000fa5);
        rd_chk("pdn_low", `BYTE_ADDR(`IDX_PDN_LOW), 8'ha5);
        rd_chk("pdn_high", `BYTE_ADDR(`IDX_PDN_HIGH), 8'h0f);
        wr(`BYTE_ADDR(`IDX_PDN_LOW), 32'h0000005a);
        wr(`BYTE_ADDR(`IDX_PDN_HIGH), 32'h000000f6);
        settle();
        check("channel_off_o", {20'h0, channel_off_o}, 32'h0000065a);
        rd_chk("pdn_high", `BYTE_ADDR(`IDX_PDN_HIGH), 8'h06);

        // temperature: top of range, then a write that must not stick
        sense(8'hc8);
        rd_chk("temp top", `BYTE_ADDR(`IDX_TEMP), 8'hc8);
        check("temp_celsius_o", {23'h0, temp_celsius_o}, {23'h0, 9'd140});
        wr(`BYTE_ADDR(`IDX_TEMP), 32'h00000055);
        rd_chk("temp read only", `BYTE_ADDR(`IDX_TEMP), 8'hc8);
        sense(8'h3d);
        rd_chk("temp one", `BYTE_ADDR(`IDX_TEMP), 8'h3d);
        check("temp_celsius_o", {23'h0, temp_celsius_o}, {23'h0, 9'd1});
        // bottom of the range, then a code above the top that must clamp;
        // four toggles in all leave the sensor pin idle low for the reset
        sense(8'h00);
        rd_chk("temp bottom", `BYTE_ADDR(`IDX_TEMP), 8'h00);
        check("temp_celsius_o", {23'h0, temp_celsius_o}, {23'h0, 9'h1c4});
        sense(8'hff);
        rd_chk("temp clamp", `BYTE_ADDR(`IDX_TEMP), 8'hc8);
        check("temp_celsius_o", {23'h0, temp_celsius_o}, {23'h0, 9'd140});

        // unmapped word answers with an error and no data
        apb_xfer(1'b0, 8'h1c, 32'h0, rd, err);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);

        // every layout code against every stereo format and rate code
        for (int l = 0; l < 8; l++) begin
            for (int f = 0; f < 4; f++) begin
                fmt = {f[1:0], l[2:0], f[1:0], f[0]};
                wr(`BYTE_ADDR(`IDX_FORMAT), {24'h0, fmt});
                settle();
                // reserved layouts fall back to stereo
                exp_layout = (l < 5) ? l[2:0] : 3'h0;
                case (f)
                    0: exp_delay = 5'h01;
                    1: exp_delay = 5'h00;
                    2: exp_delay = 5'h08;
                    default: exp_delay = 5'h10;
                endcase
                if (exp_layout != 3'h0) begin
                    exp_delay = 5'h01;
                end
                rd_chk("format", `BYTE_ADDR(`IDX_FORMAT), fmt);
                check("layout", {29'h0, audio_cfg_o.layout},
                      {29'h0, exp_layout});
                check("data_delay", {27'h0, audio_cfg_o.data_delay},
                      {27'h0, exp_delay});
                check("rate_family", {30'h0, audio_cfg_o.rate_family},
                      (f == 3) ? 32'h2 : f);
                check("low_latency", {31'h0, audio_cfg_o.low_latency},
                      {31'h0, f == 3});
                check("global_mute", {31'h0, audio_cfg_o.global_mute},
                      {31'h0, f[0]});
            end
        end

        // a second reset in mid-run must restore every default
        wr(`BYTE_ADDR(`IDX_PDN_LOW), 32'h000000ff);
        reset_and_check();
        final_report();
    end
endmodule
